/* rtl/ccr_regs.v */
// Clock gates, kernel source selects, always-on control and reset cause.
// Assumes synchronous inputs; rst_n_i is the power-on reset.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_defs.vh"

module ccr_regs #(
	parameter ADDR_W = 8
) (
	// Clock and resets
	input wire mclk_i,
	input wire rst_n_i,
	input wire sys_rst_n_i,
	input wire aon_rst_n_i,
	// AXI4-Lite write
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Status from the surroundings
	input wire always_on_write_enable_i,
	input wire slow_crystal_tick_i,
	input wire crystal_fault_i,
	input wire slow_rc_stable_i,
	input wire [6:0] reset_source_i,
	input wire core_lockup_i,
	// Clock gates
	output reg [31:0] bus1_clk_en_o,
	output reg [31:0] bus2_clk_en_o,
	// Kernel sources: converter, lp timer two, one, two-wire, lp serial one, two, timekeeper
	output wire [13:0] kernel_src_o,
	output wire [6:0] kernel_on_o,
	// Always-on controls
	output reg crystal_osc_en_o,
	output reg crystal_drive_enhanced_o,
	output reg [1:0] crystal_drive_level_o,
	output reg crystal_monitor_en_o,
	output reg timekeeper_kernel_clk_en_o,
	output wire crystal_ready_o,
	output reg always_on_soft_reset_o,
	// Cause register controls
	output reg core_lockup_reset_en_o,
	output reg slow_rc_en_o
);
	// ****************************************
	// Decoding
	// ****************************************
	function [2:0] reg_index;
		input [ADDR_W-1:0] a;
		begin
			case (a)
				`CCR_OFS_BUS1: reg_index = 3'h1;
				`CCR_OFS_BUS2: reg_index = 3'h2;
				`CCR_OFS_KSEL: reg_index = 3'h3;
				`CCR_OFS_AON: reg_index = 3'h4;
				`CCR_OFS_CAUSE: reg_index = 3'h5;
				default: reg_index = 3'h0;
			endcase
		end
	endfunction

	function [31:0] strb_mask;
		input [3:0] s;
		begin
			strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg aw_got_q;
	reg w_got_q;
	reg [ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg rd_pend_q;
	reg [ADDR_W-1:0] araddr_q;
	reg [31:0] ksel_q;
	reg [1:0] settle_q;
	reg [1:0] rtc_src_q;
	reg fail_q;
	reg [7:0] flags_q;
	reg rc_rdy_q;
	localparam [31:0] AON_RST = `CCR_AON_RESET;

	wire wr_fire;
	wire [2:0] wsel;
	wire [31:0] wmask;
	wire aon_clr;
	wire aon_wr;
	wire cause_wr;
	wire [7:0] flag_set;
	reg [31:0] aon_rd;
	reg [31:0] cause_rd;
	reg [31:0] rd_mux;
	reg [31:0] aon_m;
	reg [31:0] cause_m;
	reg [1:0] two_wire_req;

	assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
	assign wsel = reg_index(awaddr_q);
	assign wmask = strb_mask(wstrb_q);
	assign aon_clr = ~aon_rst_n_i | always_on_soft_reset_o;
	assign aon_wr = wr_fire & (wsel == 3'h4) & always_on_write_enable_i;
	assign cause_wr = wr_fire & (wsel == 3'h5);
	assign flag_set = {reset_source_i, core_lockup_i & core_lockup_reset_en_o};

	// ****************************************
	// Read values
	// ****************************************
	always @* begin
		aon_rd = 32'h00000000;
		aon_rd[21:20] = settle_q;
		aon_rd[`CCR_AON_RTC_EN] = timekeeper_kernel_clk_en_o;
		aon_rd[9:8] = rtc_src_q;
		aon_rd[6] = fail_q;
		aon_rd[`CCR_AON_MON_EN] = crystal_monitor_en_o;
		aon_rd[4:3] = crystal_drive_level_o;
		aon_rd[2] = crystal_ready_o;
		aon_rd[`CCR_AON_DRV_ENH] = crystal_drive_enhanced_o;
		aon_rd[`CCR_AON_OSC_EN] = crystal_osc_en_o;
		cause_rd = 32'h00000000;
		cause_rd[31:24] = flags_q;
		cause_rd[`CCR_CAUSE_LOCK_EN] = core_lockup_reset_en_o;
		cause_rd[1] = rc_rdy_q;
		cause_rd[`CCR_CAUSE_RC_EN] = slow_rc_en_o;
		aon_m = (aon_rd & ~wmask) | (wdata_q & wmask);
		cause_m = (cause_rd & ~wmask) | (wdata_q & wmask);
	end

	always @* begin
		case (reg_index(araddr_q))
			3'h1: rd_mux = bus1_clk_en_o;
			3'h2: rd_mux = bus2_clk_en_o;
			3'h3: rd_mux = ksel_q;
			3'h4: rd_mux = aon_rd;
			3'h5: rd_mux = cause_rd;
			default: rd_mux = 32'h00000000;
		endcase
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= {ADDR_W{1'b0}};
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_got_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped offsets answer with a slave error
				s_axi_bresp <= (wsel == 3'h0) ? 2'h2 : 2'h0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			rd_pend_q <= 1'b0;
			araddr_q <= {ADDR_W{1'b0}};
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				araddr_q <= s_axi_araddr;
				s_axi_arready <= 1'b0;
				rd_pend_q <= 1'b1;
			end
			if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= (reg_index(araddr_q) == 3'h0) ? 2'h2 : 2'h0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// Clock gates and kernel selects
	// ****************************************
	always @(posedge mclk_i) begin
		if (!rst_n_i || !sys_rst_n_i) begin
			bus1_clk_en_o <= 32'h00000000;
			bus2_clk_en_o <= 32'h00000000;
			ksel_q <= 32'h00000000;
		end else if (wr_fire) begin
			// Reserved bits are masked off and read as zero
			if (wsel == 3'h1) begin
				bus1_clk_en_o <= ((bus1_clk_en_o & ~wmask) | (wdata_q & wmask)) & `CCR_BUS1_MASK;
			end
			if (wsel == 3'h2) begin
				bus2_clk_en_o <= ((bus2_clk_en_o & ~wmask) | (wdata_q & wmask)) & `CCR_BUS2_MASK;
			end
			if (wsel == 3'h3) begin
				ksel_q <= ((ksel_q & ~wmask) | (wdata_q & wmask)) & `CCR_KSEL_MASK;
			end
		end
	end

	always @* begin
		two_wire_req = (ksel_q[13:12] == 2'h3) ? 2'h0 : ksel_q[13:12];
	end

	wire [13:0] src_req;
	assign src_req = {ksel_q[31:30], ksel_q[21:20], ksel_q[19:18], two_wire_req,
		ksel_q[11:10], ksel_q[9:8], rtc_src_q};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_sw
			ccr_src_switch u_sw (
				.mclk_i(mclk_i),
				.rst_n_i(rst_n_i),
				.req_i(src_req[2*gi+1:2*gi]),
				.sel_o(kernel_src_o[2*gi+1:2*gi]),
				.on_o(kernel_on_o[gi])
			);
		end
	endgenerate

	// ****************************************
	// Always-on domain control
	// ****************************************
	always @(posedge mclk_i) begin
		if (!rst_n_i || aon_clr) begin
			settle_q <= AON_RST[21:20];
			crystal_drive_level_o <= AON_RST[4:3];
			crystal_osc_en_o <= 1'b0;
			crystal_drive_enhanced_o <= 1'b0;
			crystal_monitor_en_o <= 1'b0;
			timekeeper_kernel_clk_en_o <= 1'b0;
			rtc_src_q <= 2'h0;
			fail_q <= 1'b0;
		end else begin
			if (!crystal_monitor_en_o) begin
				fail_q <= 1'b0;
			end else if (crystal_fault_i) begin
				fail_q <= 1'b1;
			end
			if (aon_wr) begin
				crystal_osc_en_o <= aon_m[`CCR_AON_OSC_EN];
				crystal_drive_enhanced_o <= aon_m[`CCR_AON_DRV_ENH];
				crystal_drive_level_o <= aon_m[4:3];
				timekeeper_kernel_clk_en_o <= aon_m[`CCR_AON_RTC_EN];
				if (!crystal_osc_en_o) begin
					settle_q <= aon_m[21:20];
				end
				if (aon_m[`CCR_AON_MON_EN] || fail_q) begin
					crystal_monitor_en_o <= aon_m[`CCR_AON_MON_EN];
				end
			end
			// Fault on a crystal-fed timekeeper frees the source field
			if (crystal_monitor_en_o && crystal_fault_i && rtc_src_q == `CCR_SRC_CRYSTAL) begin
				rtc_src_q <= 2'h0;
			end else if (aon_wr && rtc_src_q == 2'h0) begin
				rtc_src_q <= aon_m[9:8];
			end
		end
	end

	// The pulse itself is not cleared by the domain reset it causes
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			always_on_soft_reset_o <= 1'b0;
		end else begin
			always_on_soft_reset_o <= aon_wr & aon_m[`CCR_AON_SOFT_RST];
		end
	end

	ccr_settle_cnt u_settle (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.en_i(crystal_osc_en_o),
		.tick_i(slow_crystal_tick_i),
		.sel_i(settle_q),
		.ready_o(crystal_ready_o)
	);

	// ****************************************
	// Reset cause and slow RC
	// ****************************************
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			flags_q <= 8'h00;
			slow_rc_en_o <= 1'b0;
			rc_rdy_q <= 1'b0;
		end else begin
			// A cause arriving with the clear still lands
			if (cause_wr && cause_m[`CCR_CAUSE_CLR]) begin
				flags_q <= flag_set;
			end else begin
				flags_q <= flags_q | flag_set;
			end
			if (cause_wr) begin
				slow_rc_en_o <= cause_m[`CCR_CAUSE_RC_EN];
			end
			rc_rdy_q <= slow_rc_en_o & slow_rc_stable_i;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i || !sys_rst_n_i) begin
			core_lockup_reset_en_o <= 1'b0;
		end else if (cause_wr) begin
			core_lockup_reset_en_o <= cause_m[`CCR_CAUSE_LOCK_EN];
		end
	end
endmodule
`default_nettype wire

/* rtl/ccr_defs.vh */
// Constants for the clock select and reset cause register block.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
//
// What this block does
// - Bus one gates: display and four timers
// - Bus two gates at 0x38, six bits
// - Converter source: system clock, /2, /4, fast RC
// - Low-power timer sources: pclk, slowrc, fastrc, crystal
// - Two-wire source; code 11 acts as pclk
// - Low-power serial sources: pclk, system clock, fastrc, crystal
// - Always-on register writable only when enabled
// - Always-on register reset values per reset kind
// - Settle count chosen; changed only when oscillator off
// - Writing one resets the always-on domain
// - Bit 15 enables timekeeper kernel clock
// - Timekeeper source locks once chosen, until a monitored crystal fault
// - Failure flag sets on fault, clears monitor off
// - Monitor enable sticks unless failure detected
// - Crystal drive level, four strengths
// - Enhanced drive mode and crystal enable bits
// - Crystal ready clears while oscillator disabled
// - Cause register: power-on reset, some system reset
// - One sticky flag per reset source
// - Lockup flag only with lockup reset enabled
// - Clear-flags bit clears all, self-clears
// - Slow RC ready clears while disabled
// - Bit 0 enables slow RC oscillator
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define CCR_OFS_BUS1 8'h34
`define CCR_OFS_BUS2 8'h38
`define CCR_OFS_KSEL 8'h3c
`define CCR_OFS_AON 8'h40
`define CCR_OFS_CAUSE 8'h44

// ****************************************
// Writable masks and reset values
// ****************************************
`define CCR_BUS1_MASK 32'h0000014e
`define CCR_BUS2_MASK 32'h08105011
`define CCR_KSEL_MASK 32'hc03c3f00
`define CCR_AON_RESET 32'h00200008

// ****************************************
// Always-on and cause field positions
// ****************************************
`define CCR_AON_OSC_EN 0
`define CCR_AON_DRV_ENH 1
`define CCR_AON_MON_EN 5
`define CCR_AON_RTC_EN 15
`define CCR_AON_SOFT_RST 16
`define CCR_CAUSE_RC_EN 0
`define CCR_CAUSE_LOCK_EN 8
`define CCR_CAUSE_CLR 16
`define CCR_SRC_CRYSTAL 2'h1

// ****************************************
// Timing counts
// ****************************************
`define CCR_SETTLE_0 15'h0100
`define CCR_SETTLE_1 15'h0400
`define CCR_SETTLE_2 15'h1000
`define CCR_SETTLE_3 15'h4000
`define CCR_SW_GAP 2'h2

`endif

/* rtl/ccr_settle_cnt.v */
// Crystal start-up counter that raises the ready flag.
// Assumes tick_i is a one-cycle pulse per crystal cycle.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_defs.vh"

module ccr_settle_cnt (
	// Clock and reset
	input wire mclk_i,
	input wire rst_n_i,
	// Control
	input wire en_i,
	input wire tick_i,
	input wire [1:0] sel_i,
	// Status
	output reg ready_o
);
	reg [14:0] cnt_q;
	reg [14:0] lim;

	always @* begin
		case (sel_i)
			2'h0: lim = `CCR_SETTLE_0;
			2'h1: lim = `CCR_SETTLE_1;
			2'h2: lim = `CCR_SETTLE_2;
			default: lim = `CCR_SETTLE_3;
		endcase
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i || !en_i) begin
			cnt_q <= 15'h0000;
			ready_o <= 1'b0;
		end else if (tick_i && !ready_o) begin
			cnt_q <= cnt_q + 15'h0001;
			if (cnt_q == lim - 15'h0001) begin
				ready_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* rtl/ccr_src_switch.v */
// Clock source selector with an off gap between sources.
// Assumes the downstream mux follows sel_o only while on_o is high.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_defs.vh"

module ccr_src_switch (
	// Clock and reset
	input wire mclk_i,
	input wire rst_n_i,
	// Request
	input wire [1:0] req_i,
	// Selection
	output reg [1:0] sel_o,
	output reg on_o
);
	reg [1:0] gap_q;

	// Dropping the old source before taking the new one avoids runt pulses
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sel_o <= 2'h0;
			on_o <= 1'b1;
			gap_q <= 2'h0;
		end else if (on_o) begin
			if (req_i != sel_o) begin
				on_o <= 1'b0;
				gap_q <= 2'h0;
			end
		end else if (gap_q == `CCR_SW_GAP - 2'h1) begin
			sel_o <= req_i;
			on_o <= 1'b1;
		end else begin
			gap_q <= gap_q + 2'h1;
		end
	end
endmodule
`default_nettype wire

/* bench/ccr_regs_properties.sv */
// Port checks for the clock select and reset cause register block.
// Assumes one clock domain; bound onto every ccr_regs instance.
`timescale 1ns/100ps
`default_nettype none

module ccr_regs_properties (
	// Clock and resets
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_n_i,
	input wire logic aon_rst_n_i,
	// Watched signals
	input wire logic always_on_write_enable_i,
	input wire logic [31:0] bus1_clk_en_o,
	input wire logic [31:0] bus2_clk_en_o,
	input wire logic [13:0] kernel_src_o,
	input wire logic [6:0] kernel_on_o,
	input wire logic crystal_osc_en_o,
	input wire logic crystal_drive_enhanced_o,
	input wire logic [1:0] crystal_drive_level_o,
	input wire logic timekeeper_kernel_clk_en_o,
	input wire logic crystal_ready_o,
	input wire logic always_on_soft_reset_o,
	input wire logic core_lockup_reset_en_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// ****
	// Always-on restore, crystal ready and write enable guard
	// ****
	sequence aon_default_s;
		!crystal_osc_en_o && crystal_drive_level_o == 2'h1 &&
			!crystal_drive_enhanced_o && !timekeeper_kernel_clk_en_o;
	endsequence

	aon_rst_a: assert property (!aon_rst_n_i |=> aon_default_s)
		else $error("Domain reset left always-on fields set");
	soft_clear_a: assert property (always_on_soft_reset_o |=> aon_default_s)
		else $error("Soft reset left always-on fields set");
	pulse_len_a: assert property (always_on_soft_reset_o |=> !always_on_soft_reset_o [*3])
		else $error("Soft reset pulse too long");
	ready_clr_a: assert property (!crystal_osc_en_o |=> !crystal_ready_o)
		else $error("Ready high with oscillator off");
	wen_guard_a: assert property ($rose(crystal_osc_en_o) |->
		$past(always_on_write_enable_i) || $past(always_on_write_enable_i, 2))
		else $error("Oscillator enabled without write enable");

	// ****
	// Gates and sources
	// ****
	sys_rst_a: assert property (!sys_rst_n_i |=> bus1_clk_en_o == 32'h0 &&
		bus2_clk_en_o == 32'h0 && !core_lockup_reset_en_o)
		else $error("System reset left gates set");
	res_zero_a: assert property ((bus1_clk_en_o & ~32'h0000014e) == 32'h0 &&
		(bus2_clk_en_o & ~32'h08105011) == 32'h0)
		else $error("Reserved gate bit set");
	iic_map_a: assert property (kernel_src_o[7:6] != 2'h3)
		else $error("Two-wire code not mapped");
	// Timekeeper pair left out: domain resets clear its source field directly
	switch_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i || !sys_rst_n_i)
		$changed(kernel_src_o[13:2]) |-> $past(kernel_on_o) != 7'h7f)
		else $error("Source switched without off gap");
endmodule

bind ccr_regs ccr_regs_properties u_props (
	.mclk_i, .rst_n_i, .sys_rst_n_i, .aon_rst_n_i, .always_on_write_enable_i,
	.bus1_clk_en_o, .bus2_clk_en_o, .kernel_src_o, .kernel_on_o, .crystal_osc_en_o,
	.crystal_drive_enhanced_o, .crystal_drive_level_o, .timekeeper_kernel_clk_en_o,
	.crystal_ready_o, .always_on_soft_reset_o, .core_lockup_reset_en_o
);

`default_nettype wire

/* bench/ccr_regs_bench.sv */
// Self-checking bench for the clock select and reset cause registers.
// Assumes the port checker is bound in and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module ccr_regs_bench;
	logic mclk_i = 1'h0, rst_n_i = 1'h0, sys_rst_n_i = 1'h0, aon_rst_n_i = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, bus1_clk_en_o, bus2_clk_en_o, rdat;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, crystal_drive_level_o, rsp;
	logic always_on_write_enable_i = 1'h0, slow_crystal_tick_i = 1'h0, crystal_fault_i = 1'h0;
	logic slow_rc_stable_i = 1'h0, core_lockup_i = 1'h0;
	logic [6:0] reset_source_i = 7'h00, kernel_on_o;
	logic [13:0] kernel_src_o;
	logic crystal_osc_en_o, crystal_drive_enhanced_o, crystal_monitor_en_o, crystal_ready_o;
	logic timekeeper_kernel_clk_en_o, always_on_soft_reset_o, core_lockup_reset_en_o;
	logic slow_rc_en_o;
	int checked = 0, fail_count = 0, pulses = 0;

	ccr_regs DUT (.mclk_i, .rst_n_i, .sys_rst_n_i, .aon_rst_n_i, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .always_on_write_enable_i, .slow_crystal_tick_i, .crystal_fault_i,
		.slow_rc_stable_i, .reset_source_i, .core_lockup_i, .bus1_clk_en_o, .bus2_clk_en_o,
		.kernel_src_o, .kernel_on_o, .crystal_osc_en_o, .crystal_drive_enhanced_o,
		.crystal_drive_level_o, .crystal_monitor_en_o, .timekeeper_kernel_clk_en_o,
		.crystal_ready_o, .always_on_soft_reset_o, .core_lockup_reset_en_o, .slow_rc_en_o);

	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (always_on_soft_reset_o === 1'h1) pulses++;

	// ****
	// Bus, check and stimulus tasks
	// ****
	task check(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Valid and payload held until each channel is taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge mclk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge mclk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task wc(input logic [7:0] a, input logic [31:0] d, e);
		wr(a, d);
		rd(a);
		check(rdat, e);
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			slow_crystal_tick_i <= 1'h1;
			@(posedge mclk_i);
			slow_crystal_tick_i <= 1'h0;
		end
	endtask
	// Lockup pulses every time so the enable decides the flag
	task pulse(input logic [6:0] s);
		@(posedge mclk_i);
		reset_source_i <= s;
		core_lockup_i <= 1'h1;
		@(posedge mclk_i);
		reset_source_i <= 7'h00;
		core_lockup_i <= 1'h0;
	endtask

	// ****
	// Scenarios
	// ****
	task t_gates;
		rd(8'h40);
		check(rdat, 32'h00200008);
		rd(8'h44);
		check(rdat, 32'h0);
		wc(8'h34, 32'hffffffff, 32'h0000014e);
		check(bus1_clk_en_o, 32'h0000014e);
		wc(8'h38, 32'hffffffff, 32'h08105011);
		check(bus2_clk_en_o, 32'h08105011);
		wr(8'h48, 32'hffffffff);
		check(rsp, 2'h2);
		rd(8'h48);
		check(rsp, 2'h2);
	endtask
	task t_ksel;
		logic [1:0] a, b, e, f;
		logic [31:0] d;
		for (int c = 0; c < 4; c++) begin
			a = c[1:0];
			b = a + 2'h1;
			e = a + 2'h2;
			f = a + 2'h3;
			d = {a, 8'h00, b, e, 4'h0, f, a, b, 8'h00};
			wc(8'h3c, d, d);
			repeat (4) @(posedge mclk_i);
			check(kernel_src_o, {a, b, e, ((f == 2'h3) ? 2'h0 : f), a, b, 2'h0});
			check(kernel_on_o, 7'h7f);
		end
	endtask
	task t_aon;
		wc(8'h40, 32'h00000001, 32'h00200008);
		always_on_write_enable_i <= 1'h1;
		wc(8'h40, 32'h00008012, 32'h00008012);
		check({timekeeper_kernel_clk_en_o, crystal_drive_level_o, crystal_drive_enhanced_o}, 4'hd);
		wr(8'h40, 32'h00008013);
		tick(255);
		repeat (3) @(posedge mclk_i);
		check(crystal_ready_o, 1'h0);
		check(crystal_osc_en_o, 1'h1);
		tick(1);
		repeat (3) @(posedge mclk_i);
		check(crystal_ready_o, 1'h1);
		wc(8'h40, 32'h00308013, 32'h00008017);
		wc(8'h40, 32'h00008012, 32'h00008012);
		check(crystal_ready_o, 1'h0);
		wc(8'h40, 32'h00008112, 32'h00008112);
		wc(8'h40, 32'h00008212, 32'h00008112);
		wr(8'h40, 32'h00010000);
		rd(8'h40);
		check(rdat, 32'h00200008);
		check(pulses, 1);
		wc(8'h40, 32'h00000200, 32'h00000200);
		repeat (4) @(posedge mclk_i);
		check(kernel_src_o[1:0], 2'h2);
		wc(8'h40, 32'h00000220, 32'h00000220);
		wc(8'h40, 32'h00000200, 32'h00000220);
		check(crystal_monitor_en_o, 1'h1);
		@(posedge mclk_i);
		crystal_fault_i <= 1'h1;
		@(posedge mclk_i);
		crystal_fault_i <= 1'h0;
		rd(8'h40);
		check(rdat, 32'h00000260);
		wc(8'h40, 32'h00000200, 32'h00000200);
		@(posedge mclk_i);
		aon_rst_n_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		aon_rst_n_i <= 1'h1;
		rd(8'h40);
		check(rdat, 32'h00200008);
		// A fault while the crystal feeds the timekeeper frees its source
		wc(8'h40, 32'h00000120, 32'h00000120);
		@(posedge mclk_i);
		crystal_fault_i <= 1'h1;
		@(posedge mclk_i);
		crystal_fault_i <= 1'h0;
		rd(8'h40);
		check(rdat, 32'h00000060);
	endtask
	task t_cause;
		wc(8'h44, 32'h00000101, 32'h00000101);
		slow_rc_stable_i <= 1'h1;
		rd(8'h44);
		check(rdat, 32'h00000103);
		check({core_lockup_reset_en_o, slow_rc_en_o}, 2'h3);
		pulse(7'h7f);
		rd(8'h44);
		check(rdat, 32'hff000103);
		wc(8'h44, 32'h00010101, 32'h00000103);
		wc(8'h44, 32'h00000001, 32'h00000003);
		pulse(7'h00);
		rd(8'h44);
		check(rdat, 32'h00000003);
		wc(8'h44, 32'h00000000, 32'h00000000);
		wr(8'h44, 32'h00000101);
		wr(8'h38, 32'h00000001);
		pulse(7'h01);
		sys_rst_n_i <= 1'h0;
		repeat (3) @(posedge mclk_i);
		sys_rst_n_i <= 1'h1;
		rd(8'h44);
		check(rdat, 32'h03000003);
		check(bus2_clk_en_o, 32'h0);
	endtask

	// ****
	// Run control
	// ****
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'h1;
		sys_rst_n_i <= 1'h1;
		aon_rst_n_i <= 1'h1;
		t_gates;
		t_ksel;
		t_aon;
		t_cause;
		finish_test;
	end
	// Whole run needs about 800 cycles
	initial begin
		repeat (6000) @(posedge mclk_i);
		fail_count++;
		finish_test;
	end
endmodule

`default_nettype wire
